/* verilog/bmc_defines.vh */
// Constants for the basic mode control register block.
// Assumes inclusion by bare name from files under verilog/ and tb/.
`ifndef BMC_DEFINES_VH
`define BMC_DEFINES_VH

// Byte addresses on the register bus
`define BMC_ADDR_W          12
`define BMC_OFF_CTRL        12'h000
`define BMC_OFF_PIN_CFG     12'h100
`define BMC_OFF_STATE       12'h104

// Field positions of basic_mode_control
`define BMC_BIT_SOFT_RST    15
`define BMC_BIT_LOOPBACK    14
`define BMC_BIT_SPEED       13
`define BMC_BIT_ANEG        12
`define BMC_BIT_PDOWN       11
`define BMC_BIT_ISOLATE     10
`define BMC_BIT_DUPLEX      8
`define BMC_BIT_SPARE       7

// Reset value and fixed capability bits
`define BMC_RESET_VAL       16'h2100
`define BMC_SPEED_VAL       1'b1
`define BMC_ANEG_VAL        1'b0
`define BMC_DUPLEX_VAL      1'b1

// Field positions of the pin configuration and state registers
`define BMC_BIT_PIN_PD_EN   0
`define BMC_BIT_ST_DIG_RST  0
`define BMC_BIT_ST_PDOWN    1
`define BMC_BIT_ST_ISOLATE  2
`define BMC_BIT_ST_LOOPBACK 3
`define BMC_BIT_ST_LINK     4
`define BMC_BIT_ST_PIN      5

// Soft reset hold time, in ns, and its length in 10 ns cycles
`define BMC_CLK_PERIOD_NS   10
`define BMC_SOFT_RST_NS     1000
`define BMC_SOFT_RST_CYC    ((`BMC_SOFT_RST_NS + `BMC_CLK_PERIOD_NS - 1) / `BMC_CLK_PERIOD_NS)

// Bus responses
`define BMC_RESP_OKAY       2'b00
`define BMC_RESP_SLVERR     2'b10

`endif

/* verilog/mac_side_path.v */
// MAC-facing data path: normal pass, loopback, isolate and quiet modes.
// Assumes all inputs are on aclk; every output is a flip-flop.
`timescale 1ns/1ps
`default_nettype none

module mac_side_path #(
  parameter integer DW = 4
) (
  input  wire          aclk,
  input  wire          clr,
  input  wire          loopback,
  input  wire          isolate,
  input  wire          quiet,
  input  wire [DW-1:0] mac_txd,
  input  wire          mac_tx_en,
  input  wire [DW-1:0] line_rxd,
  input  wire          line_rx_dv,
  output reg  [DW-1:0] mac_rxd,
  output reg           mac_rx_dv,
  output reg  [DW-1:0] line_txd,
  output reg           line_tx_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Receive side toward the MAC; isolate wins so the MAC bus stays silent
  always @(posedge aclk) begin
    if (clr || isolate || quiet) begin
      mac_rxd   <= {DW{1'b0}};
      mac_rx_dv <= 1'b0;
    end else if (loopback) begin
      mac_rxd   <= mac_txd;
      mac_rx_dv <= mac_tx_en;
    end else begin
      mac_rxd   <= line_rxd;
      mac_rx_dv <= line_rx_dv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side toward the line; loopback keeps the line quiet
  always @(posedge aclk) begin
    if (clr || isolate || quiet || loopback) begin
      line_txd   <= {DW{1'b0}};
      line_tx_en <= 1'b0;
    end else begin
      line_txd   <= mac_txd;
      line_tx_en <= mac_tx_en;
    end
  end

endmodule

`default_nettype wire

/* verilog/phy_basic_mode_control.v */
// Basic mode control register of a 100 Mbit/s single-pair PHY, AXI4-Lite slave.
// Assumes one 100 MHz clock; multi-purpose pin is asynchronous, link_ok is on aclk.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.vh"

module phy_basic_mode_control #(
  parameter integer DW            = 4,
  parameter integer SOFT_RST_CYC  = `BMC_SOFT_RST_CYC
) (
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite write address
  input  wire [31:0]   s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0]   s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Multi-purpose pin, active low, asynchronous
  input  wire          mp_pin_n,
  // Link state from the PHY core
  input  wire          link_ok,
  // MAC data interface
  input  wire [DW-1:0] mac_txd,
  input  wire          mac_tx_en,
  output wire [DW-1:0] mac_rxd,
  output wire          mac_rx_dv,
  // Line side data
  input  wire [DW-1:0] line_rxd,
  input  wire          line_rx_dv,
  output wire [DW-1:0] line_txd,
  output wire          line_tx_en,
  // Control toward the PHY core
  output reg           dig_rst_n_q,
  output reg           power_down_q,
  output reg           isolate_q,
  output reg           link_up_q
);

  localparam integer CW = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg          soft_rst_q;
  reg [CW-1:0] srst_cnt_q;
  reg          loopback_q;
  reg          pdown_q;
  reg          iso_bit_q;
  reg          spare_q;
  reg          pin_pd_en_q;
  reg          pin_s1_q;
  reg          pin_s2_q;

  // Bus state
  reg          aw_full_q;
  reg          w_full_q;
  reg [11:0]   aw_addr_q;
  reg [31:0]   w_data_q;
  reg [3:0]    w_strb_q;

  wire         aw_take;
  wire         w_take;
  wire         do_write;
  wire         ar_take;
  wire         pin_pd;
  wire         pd_eff;
  wire [15:0]  ctrl_rd;
  wire [31:0]  state_rd;
  wire         wr_ctrl;
  wire         wr_pin;

  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl  = do_write && (aw_addr_q == `BMC_OFF_CTRL);
  assign wr_pin   = do_write && (aw_addr_q == `BMC_OFF_PIN_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage is read by logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= mp_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Pin acts only once software has routed it to power-down
  assign pin_pd = pin_pd_en_q && !pin_s2_q;
  assign pd_eff = pdown_q || pin_pd;

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset: bit stays set for a fixed hold, then clears itself
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_q <= 1'b0;
      srst_cnt_q <= {CW{1'b0}};
    end else if (soft_rst_q) begin
      // Writes of zero or one during the hold change nothing
      if (srst_cnt_q == SOFT_RST_CYC[CW-1:0] - 16'h0001) begin
        soft_rst_q <= 1'b0;
        srst_cnt_q <= {CW{1'b0}};
      end else begin
        srst_cnt_q <= srst_cnt_q + 16'h0001;
      end
    end else if (wr_ctrl && w_strb_q[1] && w_data_q[`BMC_BIT_SOFT_RST]) begin
      soft_rst_q <= 1'b1;
      srst_cnt_q <= {CW{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable control fields; soft reset returns them to defaults
  always @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      loopback_q <= 1'b0;
      pdown_q    <= 1'b0;
      iso_bit_q  <= 1'b0;
      spare_q    <= 1'b0;
    end else begin
      if (wr_ctrl && w_strb_q[1]) begin
        loopback_q <= w_data_q[`BMC_BIT_LOOPBACK];
        iso_bit_q  <= w_data_q[`BMC_BIT_ISOLATE];
        // A clear that meets an active pin loses to the pin
        pdown_q    <= w_data_q[`BMC_BIT_PDOWN] || pin_pd;
      end else if (pin_pd) begin
        pdown_q <= 1'b1;
      end
      if (wr_ctrl && w_strb_q[0]) begin
        spare_q <= w_data_q[`BMC_BIT_SPARE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing lives outside 0x0..0x0F, so soft reset leaves it alone
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_pd_en_q <= 1'b0;
    end else if (wr_pin && w_strb_q[0]) begin
      pin_pd_en_q <= w_data_q[`BMC_BIT_PIN_PD_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register read image; fixed bits come from constants
  assign ctrl_rd = {soft_rst_q,
                    loopback_q,
                    `BMC_SPEED_VAL,
                    `BMC_ANEG_VAL,
                    pdown_q,
                    iso_bit_q,
                    1'b0,
                    `BMC_DUPLEX_VAL,
                    spare_q,
                    7'h00};

  // Block state image
  assign state_rd = {26'h0000000,
                     !pin_s2_q,
                     link_up_q,
                     loopback_q,
                     isolate_q,
                     power_down_q,
                     !dig_rst_n_q};

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the PHY core
  always @(posedge aclk) begin
    if (!aresetn) begin
      dig_rst_n_q  <= 1'b0;
      power_down_q <= 1'b0;
      isolate_q    <= 1'b0;
      link_up_q    <= 1'b0;
    end else begin
      dig_rst_n_q  <= !soft_rst_q;
      power_down_q <= pd_eff;
      isolate_q    <= iso_bit_q;
      // Link is never reported in loopback, power-down or reset
      link_up_q    <= link_ok && !loopback_q && !pd_eff && !soft_rst_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data taken in either order, one at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BMC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr[11:0];
        s_axi_awready <= 1'b0;
      end else if (!aw_full_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        w_full_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_full_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Address bits above bit 11 are dropped, so such writes alias; other offsets refused
        if ((aw_addr_q == `BMC_OFF_CTRL) || (aw_addr_q == `BMC_OFF_PIN_CFG) ||
            (aw_addr_q == `BMC_OFF_STATE)) begin
          s_axi_bresp <= `BMC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `BMC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one outstanding read, answer the cycle after acceptance
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `BMC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `BMC_RESP_OKAY;
        case (s_axi_araddr[11:0])
          `BMC_OFF_CTRL: begin
            s_axi_rdata <= {16'h0000, ctrl_rd};
          end
          `BMC_OFF_PIN_CFG: begin
            s_axi_rdata <= {31'h00000000, pin_pd_en_q};
          end
          `BMC_OFF_STATE: begin
            s_axi_rdata <= state_rd;
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // MAC data path; power-down and soft reset silence it, bus stays alive
  mac_side_path #(
    .DW         (DW)
  ) u_path (
    .aclk       (aclk),
    .clr        (!aresetn || soft_rst_q),
    .loopback   (loopback_q),
    .isolate    (iso_bit_q),
    .quiet      (pd_eff),
    .mac_txd    (mac_txd),
    .mac_tx_en  (mac_tx_en),
    .line_rxd   (line_rxd),
    .line_rx_dv (line_rx_dv),
    .mac_rxd    (mac_rxd),
    .mac_rx_dv  (mac_rx_dv),
    .line_txd   (line_txd),
    .line_tx_en (line_tx_en)
  );

endmodule

`default_nettype wire

/* tb/bmc_props.sv */
// Checker for the basic mode control block, bound to its top module.
// Assumes one aclk domain and a synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module bmc_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        link_ok,
  input wire logic        mac_rx_dv,
  input wire logic        line_tx_en,
  input wire logic        dig_rst_n_q,
  input wire logic        power_down_q,
  input wire logic        isolate_q,
  input wire logic        link_up_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Control register address taken
  sequence s_ctrl_rd;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[11:0] == `BMC_OFF_CTRL);
  endsequence
  // Quiet data path, both directions
  sequence s_quiet;
    !mac_rx_dv && !line_tx_en;
  endsequence

  // Both halves are latched first, the response rises one cycle after that
  property p_b_lat; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  // Fixed capability bits and zero reserved bits on every control read
  property p_fixed; s_ctrl_rd |=> s_axi_rdata[13] && !s_axi_rdata[12] && s_axi_rdata[8]
    && !s_axi_rdata[9] && (s_axi_rdata[6:0] == 7'h00) && (s_axi_rdata[31:16] == 16'h0000);
  endproperty
  property p_srst; !dig_rst_n_q [*2] |-> s_quiet and !link_up_q; endproperty
  property p_iso; isolate_q [*2] |-> s_quiet; endproperty
  property p_pdown; power_down_q [*2] |-> s_quiet and !link_up_q; endproperty
  property p_link; link_up_q |-> $past(link_ok) && dig_rst_n_q; endproperty

  a_b_lat: assert property (p_b_lat) else $error("write response late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  a_srst: assert property (p_srst) else $error("active in soft reset");
  a_iso: assert property (p_iso) else $error("isolate leaks data");
  a_pdown: assert property (p_pdown) else $error("power down leaks");
  a_link: assert property (p_link) else $error("link without cause");
endmodule

bind phy_basic_mode_control bmc_props bmc_props_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .link_ok, .mac_rx_dv, .line_tx_en, .dig_rst_n_q, .power_down_q, .isolate_q, .link_up_q);
`default_nettype wire

/* tb/mac_line_model.sv */
// Far-side model: MAC transmit source and line receive source.
// Assumes aclk; patterns step every cycle so data stale by 1 to 15 cycles never looks right.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mac_line_model (
  input  wire logic       aclk,
  output var  logic [3:0] mac_txd,
  output var  logic       mac_tx_en,
  output var  logic [3:0] line_rxd,
  output var  logic       line_rx_dv
);
  // Valid held high so any leak shows at once
  initial begin
    mac_txd = 4'h0;
    line_rxd = 4'hf;
    mac_tx_en = 1'b1;
    line_rx_dv = 1'b1;
  end
  // Counters run in opposite directions to tell the two paths apart
  always @(posedge aclk) begin
    mac_txd <= mac_txd + 4'h1;
    line_rxd <= line_rxd - 4'h1;
  end
endmodule
`default_nettype wire

/* tb/test_phy_basic_mode_control.sv */
// Bench for the basic mode control block: AXI4-Lite tasks, directed tests.
// Assumes the defines header and the far-side data model beside the design.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module test_phy_basic_mode_control;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, mp_pin_n, link_ok;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  mac_txd, mac_rxd, line_rxd, line_txd;
  wire         mac_tx_en, mac_rx_dv, line_rx_dv, line_tx_en;
  wire         dig_rst_n_q, power_down_q, isolate_q, link_up_q;
  integer      num_errors = 0;
  integer      checked = 0;
  integer      n;
  logic [3:0]  t;

  // Short soft reset keeps the run brief
  phy_basic_mode_control #(.DW(4), .SOFT_RST_CYC(4)) phy_basic_mode_control_i (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mp_pin_n,
    .link_ok, .mac_txd, .mac_tx_en, .mac_rxd, .mac_rx_dv, .line_rxd, .line_rx_dv,
    .line_txd, .line_tx_en, .dig_rst_n_q, .power_down_q, .isolate_q, .link_up_q);
  mac_line_model mac_line_model_i (.aclk, .mac_txd, .mac_tx_en, .line_rxd, .line_rx_dv);

  ////////////////////////////////////////////////////////////////////////////////
  // Compare; case inequality so unknowns never pass
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One write; halves offered together, each released once taken
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // One read, data and response compared
  task rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task stop_test;
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Watchdog: the tests need well under 2000 cycles
  initial begin
    #20000;
    num_errors = num_errors + 1;
    stop_test;
  end
  // Directed tests
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, link_ok} = '0;
    mp_pin_n = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    wr(`BMC_OFF_CTRL, 32'h7fff, `BMC_RESP_OKAY);
    rdc(`BMC_OFF_CTRL, 32'h6d80, `BMC_RESP_OKAY);
    link_ok <= 1'b1;
    wr(`BMC_OFF_CTRL, 32'h0, `BMC_RESP_OKAY);
    rdc(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    chk("link", 1, link_up_q);
    chk("rx_dv", 1, mac_rx_dv);
    t = mac_txd;
    @(posedge aclk);
    chk("pass_txd", {28'h0, t}, {28'h0, line_txd});
    wr(`BMC_OFF_CTRL, 32'h6100, `BMC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    t = mac_txd;
    @(posedge aclk);
    chk("lb_data", {28'h0, t}, {28'h0, mac_rxd});
    chk("lb_link", 0, link_up_q);
    chk("lb_tx", 0, line_tx_en);
    rdc(`BMC_OFF_STATE, 32'h8, `BMC_RESP_OKAY);
    wr(`BMC_OFF_CTRL, 32'h2500, `BMC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("iso_dv", 0, mac_rx_dv);
    chk("iso_tx", 0, line_tx_en);
    rdc(`BMC_OFF_CTRL, 32'h2500, `BMC_RESP_OKAY);
    wr(`BMC_OFF_CTRL, 32'h2900, `BMC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("pd", 1, power_down_q);
    chk("pd_tx", 0, line_tx_en);
    rdc(`BMC_OFF_CTRL, 32'h2900, `BMC_RESP_OKAY);
    wr(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    // Pin low before it is routed must not power down
    mp_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("pin_off", 0, power_down_q);
    wr(`BMC_OFF_PIN_CFG, 32'h1, `BMC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("pin_pd", 1, power_down_q);
    rdc(`BMC_OFF_STATE, 32'h22, `BMC_RESP_OKAY);
    wr(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    rdc(`BMC_OFF_CTRL, 32'h2900, `BMC_RESP_OKAY);
    mp_pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    rdc(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    wr(`BMC_OFF_CTRL, 32'h4480, `BMC_RESP_OKAY);
    // Soft reset written with fields set, so only the reset can clear them
    wr(`BMC_OFF_CTRL, 32'hc480, `BMC_RESP_OKAY);
    for (n = 0; n < 10 && dig_rst_n_q !== 1'b0; n = n + 1) @(posedge aclk);
    @(posedge aclk);
    chk("srst_dig", 0, dig_rst_n_q);
    chk("srst_iso", 0, isolate_q);
    for (n = 0; n < 30 && dig_rst_n_q !== 1'b1; n = n + 1) @(posedge aclk);
    chk("srst_end", 1, dig_rst_n_q);
    rdc(`BMC_OFF_CTRL, 32'h2100, `BMC_RESP_OKAY);
    rdc(`BMC_OFF_PIN_CFG, 32'h1, `BMC_RESP_OKAY);
    rdc(12'h008, 32'h0, `BMC_RESP_SLVERR);
    wr(12'h008, 32'hffff, `BMC_RESP_SLVERR);
    stop_test;
  end
endmodule
`default_nettype wire
